/* rtl/cca_capture_regs.sv */
`timescale 1ns/100ps
// Overview of operation
// - with a channel's modulation enable set, that channel drives a pulse-width waveform on its compare output pin.
// - modulation uses 8 to 11 bit resolution with the wide select clear, and 16 bit resolution with it set.
// - with modulation enable and toggle enable both set, the channel is a frequency-output generator instead.
// - a channel requests an interrupt only while its flag interrupt enable is 1 and its compare flag is set.
// - the 16-bit free-running counter is read and written as a low byte at 0xF9 and a high byte at 0xFA.
// - while the watchdog enable is 1, software writes to both counter bytes are ignored.
// - the counter high byte reads a snapshot that is loaded from the live high byte only when the low byte is read.
// - each of the three channels has a read-write compare low byte at 0xFB, 0xE9 and 0xEB.
// - the auto-reload select bit makes the channel compare byte addresses reach the auto-reload bytes instead; mode bytes are unaffected.
// - any write to a channel compare low byte clears that channel's comparator enable.
// - any write to a channel compare high byte sets that channel's comparator enable.
module cca_capture_regs #(
  parameter int NUM_CHAN = 3
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // special-function register bus
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  // counter control
  input wire logic watchdog_enable_in,
  input wire logic count_enable_in,
  // channel events and outputs
  input wire logic [NUM_CHAN-1:0] chan_flag_clear_in,
  output logic [NUM_CHAN-1:0] chan_capture_compare_flag_out,
  output logic [NUM_CHAN-1:0] chan_irq_req_out,
  output logic [NUM_CHAN-1:0] chan_compare_output_pin_out
);

  // addresses are fixed per channel, so the count cannot change
  if (NUM_CHAN != 3) begin : g_chan_check
    $error("cca_capture_regs supports exactly three channels");
  end

  // resolution select is decoded as two bits, and the resolution, auto-reload select and wide fields must sit inside their byte
  if (cca_pkg::MODCTL_RES_W != 2 || cca_pkg::MODCTL_RES_LSB + cca_pkg::MODCTL_RES_W > 8 ||
      cca_pkg::MODCTL_AUTORELOAD_SELECT_BIT > 7 || cca_pkg::MODE_WIDE_BIT > 7) begin : g_field_check
    $error("register fields do not fit the byte layout");
  end

  logic [15:0] counter_ff;
  logic [15:0] nxt_counter;
  logic [7:0] snapshot_ff;
  logic [7:0] mod_ctrl_ff;
  logic [7:0] rdata_ff;
  logic [NUM_CHAN-1:0][7:0] cmp_lo_ff;
  logic [NUM_CHAN-1:0][7:0] cmp_hi_ff;
  logic [NUM_CHAN-1:0][7:0] reload_lo_ff;
  logic [NUM_CHAN-1:0][7:0] reload_hi_ff;
  logic [NUM_CHAN-1:0][7:0] mode_ff;
  logic [NUM_CHAN-1:0][15:0] pwm_cmp_ff;
  logic [NUM_CHAN-1:0] flag_ff;
  logic [NUM_CHAN-1:0] pin_ff;
  logic [NUM_CHAN-1:0] wr_lo;
  logic [NUM_CHAN-1:0] wr_hi;
  logic [NUM_CHAN-1:0] wr_mode;
  logic [NUM_CHAN-1:0] match;
  logic [NUM_CHAN-1:0] lo_match;
  logic [NUM_CHAN-1:0] mod_en;
  logic [NUM_CHAN-1:0] toggle_en;
  logic [NUM_CHAN-1:0] wide_sel;
  logic [NUM_CHAN-1:0] cmp_en;
  logic [NUM_CHAN-1:0] irq_en;
  logic [NUM_CHAN-1:0] freq_step;
  logic [NUM_CHAN-1:0][15:0] cmp_word;
  logic [7:0] nxt_rdata;
  logic autoreload_select;
  logic [1:0] res_sel;
  logic [3:0] mask_shift;
  logic narrow8;
  logic [15:0] res_mask;
  logic narrow_wrap;
  logic wr_cnt_lo;
  logic wr_cnt_hi;

  assign autoreload_select = mod_ctrl_ff[cca_pkg::MODCTL_AUTORELOAD_SELECT_BIT];
  assign res_sel = mod_ctrl_ff[cca_pkg::MODCTL_RES_LSB +: cca_pkg::MODCTL_RES_W];
  assign narrow8 = res_sel == 2'b00;
  // mask of the active low bits for 8 to 11 bit modulation
  assign mask_shift = cca_pkg::NARROW_BASE_SHIFT - {2'b00, res_sel};
  assign res_mask = cca_pkg::FULL_MASK >> mask_shift;
  assign narrow_wrap = (counter_ff & res_mask) == res_mask;
  assign wr_cnt_lo = sfr_wr_in && (sfr_addr_in == cca_pkg::ADDR_CNT_LO) && !watchdog_enable_in;
  assign wr_cnt_hi = sfr_wr_in && (sfr_addr_in == cca_pkg::ADDR_CNT_HI) && !watchdog_enable_in;

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      wr_lo[i] = sfr_wr_in && (sfr_addr_in == cca_pkg::ADDR_CMP_LO[i]);
      wr_hi[i] = sfr_wr_in && (sfr_addr_in == cca_pkg::ADDR_CMP_HI[i]);
      wr_mode[i] = sfr_wr_in && (sfr_addr_in == cca_pkg::ADDR_MODE[i]);
      cmp_word[i] = {cmp_hi_ff[i], cmp_lo_ff[i]};
      match[i] = counter_ff == cmp_word[i];
      lo_match[i] = counter_ff[7:0] == cmp_lo_ff[i];
    end
  end

  // mode fields decoded once per channel
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      mod_en[i] = mode_ff[i][cca_pkg::MODE_MOD_EN_BIT];
      toggle_en[i] = mode_ff[i][cca_pkg::MODE_TOGGLE_BIT];
      wide_sel[i] = mode_ff[i][cca_pkg::MODE_WIDE_BIT];
      cmp_en[i] = mode_ff[i][cca_pkg::MODE_CMP_EN_BIT];
      irq_en[i] = mode_ff[i][cca_pkg::MODE_IRQ_EN_BIT];
      freq_step[i] = mod_en[i] && toggle_en[i] && lo_match[i];
    end
  end

  // free-running counter; a software write wins over the count
  always_comb begin
    nxt_counter = count_enable_in ? counter_ff + 16'h0001 : counter_ff;
    if (wr_cnt_lo) begin
      nxt_counter[7:0] = sfr_wdata_in;
    end
    if (wr_cnt_hi) begin
      nxt_counter[15:8] = sfr_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      counter_ff <= cca_pkg::RST_WORD;
    end else begin
      counter_ff <= nxt_counter;
    end
  end

  // snapshot keeps a 16-bit read coherent across two byte reads
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      snapshot_ff <= cca_pkg::RST_BYTE;
    end else if (sfr_rd_in && sfr_addr_in == cca_pkg::ADDR_CNT_LO) begin
      snapshot_ff <= counter_ff[15:8];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mod_ctrl_ff <= cca_pkg::RST_BYTE;
    end else if (sfr_wr_in && sfr_addr_in == cca_pkg::ADDR_MOD_CTRL) begin
      mod_ctrl_ff <= sfr_wdata_in;
    end
  end

  // compare low byte; frequency mode advances it by the high byte
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmp_lo_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (wr_lo[i] && !autoreload_select) begin
          cmp_lo_ff[i] <= sfr_wdata_in;
        end else if (freq_step[i]) begin
          cmp_lo_ff[i] <= cmp_lo_ff[i] + cmp_hi_ff[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmp_hi_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (wr_hi[i] && !autoreload_select) begin
          cmp_hi_ff[i] <= sfr_wdata_in;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reload_lo_ff <= '0;
      reload_hi_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (wr_lo[i] && autoreload_select) begin
          reload_lo_ff[i] <= sfr_wdata_in;
        end
        if (wr_hi[i] && autoreload_select) begin
          reload_hi_ff[i] <= sfr_wdata_in;
        end
      end
    end
  end

  // mode bits; byte writes override the comparator enable
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (wr_mode[i]) begin
          mode_ff[i] <= sfr_wdata_in;
        end else if (wr_lo[i]) begin
          mode_ff[i][cca_pkg::MODE_CMP_EN_BIT] <= 1'b0;
        end else if (wr_hi[i]) begin
          mode_ff[i][cca_pkg::MODE_CMP_EN_BIT] <= 1'b1;
        end
      end
    end
  end

  // narrow modulation threshold only reloads at wrap, avoiding glitches mid-period
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pwm_cmp_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (narrow_wrap) begin
          if (narrow8) begin
            pwm_cmp_ff[i] <= {8'h00, cmp_hi_ff[i]};
          end else begin
            pwm_cmp_ff[i] <= {reload_hi_ff[i], reload_lo_ff[i]} & res_mask;
          end
        end
      end
    end
  end

  // compare flag: a match in the clear cycle still sets it
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flag_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        flag_ff[i] <= (flag_ff[i] && !chan_flag_clear_in[i]) ||
          (cmp_en[i] && match[i]);
      end
    end
  end

  // compare output pin
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (mod_en[i]) begin
          if (toggle_en[i]) begin
            pin_ff[i] <= freq_step[i] ? !pin_ff[i] : pin_ff[i];
          end else if (wide_sel[i]) begin
            pin_ff[i] <= counter_ff < cmp_word[i];
          end else begin
            pin_ff[i] <= (counter_ff & res_mask) < pwm_cmp_ff[i];
          end
        end else if (toggle_en[i] && cmp_en[i] && match[i]) begin
          pin_ff[i] <= !pin_ff[i];
        end
      end
    end
  end

  // read mux; unmapped addresses give zero
  always_comb begin
    nxt_rdata = cca_pkg::RST_BYTE;
    case (sfr_addr_in)
      cca_pkg::ADDR_CNT_LO: begin
        nxt_rdata = counter_ff[7:0];
      end
      cca_pkg::ADDR_CNT_HI: begin
        nxt_rdata = snapshot_ff;
      end
      cca_pkg::ADDR_MOD_CTRL: begin
        nxt_rdata = mod_ctrl_ff;
      end
      default: begin
        for (int i = 0; i < NUM_CHAN; i++) begin
          if (sfr_addr_in == cca_pkg::ADDR_CMP_LO[i]) begin
            nxt_rdata = autoreload_select ? reload_lo_ff[i] : cmp_lo_ff[i];
          end
          if (sfr_addr_in == cca_pkg::ADDR_CMP_HI[i]) begin
            nxt_rdata = autoreload_select ? reload_hi_ff[i] : cmp_hi_ff[i];
          end
          if (sfr_addr_in == cca_pkg::ADDR_MODE[i]) begin
            nxt_rdata = mode_ff[i];
          end
        end
      end
    endcase
  end

  // read data, one cycle after the read strobe, held until the next read
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_ff <= cca_pkg::RST_BYTE;
    end else if (sfr_rd_in) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      chan_irq_req_out[i] = flag_ff[i] && irq_en[i];
    end
  end

  assign sfr_rdata_out = rdata_ff;
  assign chan_capture_compare_flag_out = flag_ff;
  assign chan_compare_output_pin_out = pin_ff;

endmodule

/* rtl/cca_pkg.sv */
package cca_pkg;
  // special-function addresses
  localparam logic [7:0] ADDR_CNT_LO = 8'hF9;
  localparam logic [7:0] ADDR_CNT_HI = 8'hFA;
  localparam logic [7:0] ADDR_MOD_CTRL = 8'hF7;
  localparam logic [2:0][7:0] ADDR_CMP_LO = {8'hEB, 8'hE9, 8'hFB};
  localparam logic [2:0][7:0] ADDR_CMP_HI = {8'hEC, 8'hEA, 8'hFC};
  localparam logic [2:0][7:0] ADDR_MODE = {8'hDC, 8'hDB, 8'hDA};

  // channel mode register fields
  localparam int MODE_WIDE_BIT = 7;
  localparam int MODE_CMP_EN_BIT = 6;
  localparam int MODE_TOGGLE_BIT = 2;
  localparam int MODE_MOD_EN_BIT = 1;
  localparam int MODE_IRQ_EN_BIT = 0;

  // modulation control register fields
  localparam int MODCTL_AUTORELOAD_SELECT_BIT = 7;
  localparam int MODCTL_RES_LSB = 0;
  localparam int MODCTL_RES_W = 2;

  // reset values, resolution mask and shift base
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] FULL_MASK = 16'hFFFF;
  localparam logic [3:0] NARROW_BASE_SHIFT = 4'h8;
endpackage

/* tb/cca_capture_regs_assertions.sv */
`timescale 1ns/100ps
module cca_capture_regs_assertions #(
  parameter int NUM_CHAN = 3
) (
  // clock, reset and bus
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic watchdog_enable_in,
  input wire logic count_enable_in,
  // channel outputs
  input wire logic [NUM_CHAN-1:0] chan_capture_compare_flag_out,
  input wire logic [NUM_CHAN-1:0] chan_irq_req_out,
  input wire logic [NUM_CHAN-1:0] chan_compare_output_pin_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence rd_at(logic [7:0] a);
    sfr_rd_in && sfr_addr_in == a;
  endsequence
  sequence wr_at(logic [7:0] a);
    sfr_wr_in && sfr_addr_in == a;
  endsequence
  irq_needs_flag_a: assert property ((chan_irq_req_out & ~chan_capture_compare_flag_out) == '0)
    else $error("irq without flag");
  rdata_holds_a: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (rd_at(8'h00) |=> sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  cmp_readback_a: assert property (wr_at(8'hFB) ##1 rd_at(8'hFB) |=> sfr_rdata_out == $past(sfr_wdata_in, 2))
    else $error("compare low readback wrong");
  cnt_write_a: assert property ((wr_at(8'hF9) ##0 !watchdog_enable_in && !count_enable_in ##1 rd_at(8'hF9))
    |=> sfr_rdata_out == $past(sfr_wdata_in, 2))
    else $error("counter low write lost");
  // counter must stand still so the second read can be compared with the first
  wdog_lock_a: assert property ((rd_at(8'hF9) ##0 !count_enable_in ##1 wr_at(8'hF9) ##0
    watchdog_enable_in && !count_enable_in ##1 rd_at(8'hF9)) |=> sfr_rdata_out == $past(sfr_rdata_out, 2))
    else $error("counter written while locked");
  snap_hold_a: assert property ((rd_at(8'hFA) ##1 !sfr_wr_in && !(sfr_rd_in && sfr_addr_in == 8'hF9)
    ##1 rd_at(8'hFA)) |=> sfr_rdata_out == $past(sfr_rdata_out, 2))
    else $error("snapshot changed without low read");
  ecom_clear_a: assert property (wr_at(8'hFB) ##1 rd_at(8'hDA) |=> !sfr_rdata_out[6])
    else $error("comparator enable not cleared");
  ecom_set_a: assert property (wr_at(8'hFC) ##1 rd_at(8'hDA) |=> sfr_rdata_out[6])
    else $error("comparator enable not set");
  reset_zero_a: assert property ($rose(rstn_in) |-> sfr_rdata_out == 8'h00 && chan_irq_req_out == '0 &&
    chan_compare_output_pin_out == '0 && chan_capture_compare_flag_out == '0)
    else $error("outputs not zero after reset");
endmodule
bind cca_capture_regs cca_capture_regs_assertions #(.NUM_CHAN(NUM_CHAN)) i_cca_capture_regs_assertions (
  .ref_clk_in, .rstn_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
  .watchdog_enable_in, .count_enable_in, .chan_capture_compare_flag_out, .chan_irq_req_out,
  .chan_compare_output_pin_out);

/* tb/cca_capture_regs_tb_top.sv */
`timescale 1ns/100ps
module cca_capture_regs_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wdg = 1'b0;
  logic cen = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [2:0] fclr = 3'h0;
  logic [7:0] rdat;
  logic [2:0] flag;
  logic [2:0] irq;
  logic [2:0] pin;
  logic [7:0] v;
  logic [7:0] x;
  logic p;
  int k;
  int n_mismatch = 0;
  int num_checks = 0;
  localparam logic [7:0] RA [9] = '{8'hF9, 8'hFA, 8'hFB, 8'hE9, 8'hEB, 8'hDA, 8'hDB, 8'hDC, 8'h00};
  cca_capture_regs i_cca_capture_regs (.ref_clk_in(clk), .rstn_in(rstn), .sfr_addr_in(adr), .sfr_wr_in(wr),
    .sfr_rd_in(rd), .sfr_wdata_in(wd), .sfr_rdata_out(rdat), .watchdog_enable_in(wdg), .count_enable_in(cen),
    .chan_flag_clear_in(fclr), .chan_capture_compare_flag_out(flag), .chan_irq_req_out(irq),
    .chan_compare_output_pin_out(pin));
  initial begin
    forever #2 clk = ~clk;
  end
  function automatic logic pexp(logic [15:0] cnt, logic [15:0] cmp);
    return cnt < cmp;
  endfunction
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // strobes stay up until the next call so no signal is assigned twice in one step
  task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] d);
    wr = w;
    rd = r;
    adr = a;
    wd = d;
    @(posedge clk);
    #1;
  endtask
  task automatic idle(int n);
    wr = 1'b0;
    rd = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end
  initial begin
    void'($urandom(32'h30FD));
    repeat (10) @(posedge clk);
    #1;
    rstn = 1'b1;
    idle(1);
    foreach (RA[i]) begin
      bus(1'b0, 1'b1, RA[i], 8'h00);
      chk("reset", rdat, 8'h00);
    end
    for (int c = 0; c < 3; c++) begin
      v = 8'($urandom());
      bus(1'b1, 1'b0, cca_pkg::ADDR_CMP_LO[c], v);
      bus(1'b0, 1'b1, cca_pkg::ADDR_CMP_LO[c], 8'h00);
      chk("cmp_lo", rdat, v);
      bus(1'b1, 1'b0, cca_pkg::ADDR_CMP_HI[c], 8'h00);
      bus(1'b0, 1'b1, cca_pkg::ADDR_MODE[c], 8'h00);
      chk("ecom_set", rdat[6], 1'b1);
      bus(1'b1, 1'b0, cca_pkg::ADDR_CMP_LO[c], 8'h40);
      bus(1'b0, 1'b1, cca_pkg::ADDR_MODE[c], 8'h00);
      chk("ecom_clr", rdat[6], 1'b0);
      k = $urandom_range(8, 1);
      bus(1'b1, 1'b0, cca_pkg::ADDR_MODE[c], 8'h40);
      bus(1'b1, 1'b0, 8'hFA, 8'h00);
      bus(1'b1, 1'b0, 8'hF9, 8'(8'h40 - k));
      cen = 1'b1;
      idle(k + 2);
      cen = 1'b0;
      bus(1'b0, 1'b1, 8'hF9, 8'h00);
      chk("count", rdat, 8'(8'h42));
      chk("flag", flag[c], 1'b1);
      chk("irq_off", irq[c], 1'b0);
      bus(1'b1, 1'b0, cca_pkg::ADDR_MODE[c], 8'h41);
      chk("irq_on", irq[c], 1'b1);
      fclr[c] = 1'b1;
      idle(1);
      fclr = 3'h0;
      idle(1);
      chk("irq_clr", irq[c], 1'b0);
      bus(1'b1, 1'b0, cca_pkg::ADDR_MODE[c], 8'h82);
      idle(2);
      chk("pin_hi_cnt", pin[c], pexp(16'h0042, 16'h0040));
      x = 8'($urandom_range(63));
      bus(1'b1, 1'b0, 8'hF9, x);
      idle(2);
      chk("pin_lo_cnt", pin[c], pexp({8'h00, x}, 16'h0040));
      bus(1'b1, 1'b0, cca_pkg::ADDR_MODE[c], 8'h00);
    end
    v = 8'($urandom());
    bus(1'b1, 1'b0, 8'hFA, v);
    bus(1'b1, 1'b0, 8'hF9, 8'h11);
    bus(1'b0, 1'b1, 8'hF9, 8'h00);
    chk("cnt_lo", rdat, 8'h11);
    bus(1'b1, 1'b0, 8'hFA, ~v);
    bus(1'b0, 1'b1, 8'hFA, 8'h00);
    chk("snap", rdat, v);
    bus(1'b0, 1'b1, 8'hFB, 8'h00);
    bus(1'b0, 1'b1, 8'hFA, 8'h00);
    chk("snap_hold", rdat, v);
    wdg = 1'b1;
    bus(1'b0, 1'b1, 8'hF9, 8'h00);
    bus(1'b1, 1'b0, 8'hF9, 8'h22);
    bus(1'b0, 1'b1, 8'hF9, 8'h00);
    chk("wdog_lo", rdat, 8'h11);
    bus(1'b1, 1'b0, 8'hFA, v);
    bus(1'b0, 1'b1, 8'hFA, 8'h00);
    chk("wdog_hi", rdat, ~v);
    wdg = 1'b0;
    x = 8'($urandom());
    bus(1'b1, 1'b0, 8'hF7, 8'h80);
    bus(1'b1, 1'b0, 8'hFB, x);
    bus(1'b1, 1'b0, 8'hF7, 8'h00);
    bus(1'b0, 1'b1, 8'hFB, 8'h00);
    chk("cmp_kept", rdat, 8'h40);
    bus(1'b1, 1'b0, 8'hF7, 8'h80);
    bus(1'b0, 1'b1, 8'hFB, 8'h00);
    chk("reload", rdat, x);
    v = 8'($urandom());
    x = 8'($urandom());
    bus(1'b1, 1'b0, 8'hF7, 8'h00);
    bus(1'b1, 1'b0, 8'hFC, v);
    bus(1'b1, 1'b0, 8'hDA, 8'h02);
    bus(1'b1, 1'b0, 8'hF9, 8'hFF);
    bus(1'b1, 1'b0, 8'hF9, x);
    idle(2);
    chk("pwm8", pin[0], pexp({8'h00, x}, {8'h00, v}));
    k = $urandom_range(255, 1);
    bus(1'b1, 1'b0, 8'hF9, 8'h00);
    bus(1'b1, 1'b0, 8'hE9, 8'h20);
    bus(1'b1, 1'b0, 8'hEA, 8'(k));
    bus(1'b1, 1'b0, 8'hDB, 8'h06);
    p = pin[1];
    bus(1'b1, 1'b0, 8'hF9, 8'h20);
    idle(1);
    bus(1'b0, 1'b1, 8'hE9, 8'h00);
    chk("freq_step", rdat, 8'(8'h20 + k));
    chk("freq_pin", pin[1], !p);
    idle(2);
    summarize();
  end
endmodule
